// *** bench/ptg_loop.sv ***
// Far-side loopback model: returns the generated stream to the checker input
`timescale 1ns/1ns
module ptg_loop (
    // Clock
    input wire clk_i,
    // Stream from the generator
    input wire [7:0] gen_data_i,
    input wire gen_valid_i,
    input wire gen_eop_i,
    // Error injection, inverts every eighth byte
    input wire corrupt_i,
    // Stream to the checker
    output reg [7:0] chk_data_o,
    output reg chk_valid_o,
    output reg chk_eop_o
);
    reg [2:0] cnt_q;
    initial begin
        cnt_q = 3'h0;
        chk_data_o = 8'h5A;
        chk_valid_o = 1'b0;
        chk_eop_o = 1'b0;
    end
    always @(posedge clk_i) begin
        chk_valid_o <= gen_valid_i;
        chk_eop_o <= gen_valid_i && gen_eop_i;
        // Idle data toggles so a stale byte is never mistaken for a valid one
        if (!gen_valid_i)
            chk_data_o <= ~chk_data_o;
        else if (corrupt_i && cnt_q == 3'h7)
            chk_data_o <= ~gen_data_i;
        else
            chk_data_o <= gen_data_i;
        if (gen_valid_i)
            cnt_q <= cnt_q + 3'h1;
    end
endmodule // ptg_loop

// *** bench/ptg_sva_checker.sv ***
// Port-level assertions for the test traffic block
`timescale 1ns/1ns
module ptg_sva (
    // Clock and reset
    input wire CLK_I,
    input wire SRST_I,
    // APB
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [31:0] PRDATA_O,
    input wire PREADY_O,
    input wire PSLVERR_O,
    // Generated stream
    input wire GEN_VALID_O,
    input wire GEN_SOP_O,
    input wire GEN_EOP_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    wire acc = PSEL_I && PENABLE_I;
    wire rd_acc = acc && !PWRITE_I;
    property p_ready; acc |-> PREADY_O; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access phase");
    property p_err_phase; PSLVERR_O |-> acc; endproperty
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access phase");
    property p_err_zero; rd_acc && PSLVERR_O |-> PRDATA_O == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
    property p_hi_zero; rd_acc |-> PRDATA_O[31:16] == 16'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read half not zero");
    property p_mark_valid; (GEN_SOP_O || GEN_EOP_O) |-> GEN_VALID_O; endproperty
    a_mark_valid: assert property (p_mark_valid) else $error("packet marker without valid");
    property p_start; $rose(GEN_VALID_O) |-> GEN_SOP_O; endproperty
    a_start: assert property (p_start) else $error("packet began without start marker");
    property p_da_run; GEN_SOP_O |-> GEN_VALID_O [*6]; endproperty
    a_da_run: assert property (p_da_run) else $error("address bytes not contiguous");
    property p_pkt_len; GEN_SOP_O |-> ##63 GEN_EOP_O; endproperty
    a_pkt_len: assert property (p_pkt_len) else $error("packet length not 64");
    property p_ipg; GEN_EOP_O |=> !GEN_VALID_O [*8]; endproperty
    a_ipg: assert property (p_ipg) else $error("gap after packet too short");
    c_pkt: cover property (GEN_SOP_O);
    c_refused: cover property (rd_acc && PSLVERR_O);
    c_b2b: cover property (GEN_EOP_O ##13 GEN_SOP_O);
endmodule // ptg_sva
bind ptg_top ptg_sva ptg_sva_i (.CLK_I(CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .GEN_VALID_O(GEN_VALID_O), .GEN_SOP_O(GEN_SOP_O), .GEN_EOP_O(GEN_EOP_O));

// *** bench/ptg_top_test.sv ***
// Self-checking bench: registers, generator, checker and frame counters
`timescale 1ns/1ns
`include "ptg_map.vh"
module ptg_top_test;
    localparam logic [32:0] FULL = 33'h1FFFFFFFF;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [15:0] paddr = 16'h0;
    reg psel = 1'b0;
    reg pen = 1'b0;
    reg pwr = 1'b0;
    reg [31:0] pwdata = 32'h0;
    reg corrupt = 1'b0;
    reg [3:0] ev = 4'h0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [7:0] gdata;
    wire [7:0] cdata;
    wire gvalid, gsop, geop, cvalid, ceop;
    int err_total = 0;
    int samples_checked = 0;
    int sop_cnt = 0;
    int i, g, c[4];
    logic [32:0] rq[$], rm[$], m;
    logic [7:0] gq[$], gm[$], b;
    reg [47:0] da, pat;
    reg [7:0] fix;
    reg [2:0] plen;
    always #5 clk = ~clk;
    ptg_top ptg_top_i (.CLK_I(clk), .SRST_I(rst), .PADDR_I(paddr), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .GEN_DATA_O(gdata), .GEN_VALID_O(gvalid), .GEN_SOP_O(gsop), .GEN_EOP_O(geop), .CHK_DATA_I(cdata),
        .CHK_VALID_I(cvalid), .CHK_EOP_I(ceop), .TX_PKT_I(ev[0]), .TX_CRC_ERR_I(ev[1]), .RX_PKT_I(ev[2]),
        .RX_CRC_ERR_I(ev[3]));
    ptg_loop ptg_loop_i (.clk_i(clk), .gen_data_i(gdata), .gen_valid_i(gvalid), .gen_eop_i(geop),
        .corrupt_i(corrupt), .chk_data_o(cdata), .chk_valid_o(cvalid), .chk_eop_o(ceop));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Read results and generated bytes are compared in arrival order
    always @(posedge clk) begin
        if (psel && pen && !pwr && pready === 1'b1 && rq.size() > 0) begin
            m = rm.pop_front();
            check({pslverr, prdata} & m, rq.pop_front() & m);
        end
        if (gvalid === 1'b1) begin
            sop_cnt += (gsop === 1'b1);
            if (gq.size() > 0) begin
                b = gm.pop_front();
                check(gdata & b, gq.pop_front() & b);
            end
        end
    end
    // Leaves psel and penable high; cyc releases them between groups
    task automatic apb(input logic [11:0] idx, input logic w, input logic [15:0] d);
        int n;
        paddr <= {2'b00, idx, 2'b00};
        pwr <= w;
        pwdata <= {16'h0, d};
        psel <= 1'b1;
        pen <= 1'b0;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            report_and_stop();
        end
    endtask
    task automatic rd(input int idx, input logic [32:0] exp, input logic [32:0] mk);
        rq.push_back(exp);
        rm.push_back(mk);
        apb(12'(idx), 1'b0, 16'h0);
    endtask
    task automatic wr(input int idx, input logic [15:0] d);
        apb(12'(idx), 1'b1, d);
    endtask
    task automatic cyc(input int n);
        psel <= 1'b0;
        pen <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse(input int bit_n, input int n);
        repeat (n) begin
            ev[bit_n] <= 1'b1;
            @(posedge clk);
            ev[bit_n] <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic run(input logic [1:0] mode, input logic [2:0] cnt, input int npk);
        int n, k, s0, np;
        {fix, plen, da, pat} = 107'({$urandom, $urandom, $urandom, $urandom});
        np = (plen > 3'h6) ? 6 : plen;
        wr(`PTG_IDX_GCFG, {fix, mode, plen, cnt});
        rd(`PTG_IDX_GCFG, {17'h0, fix, mode, plen, cnt}, (plen > 3'h6) ? FULL ^ 33'h38 : FULL);
        for (k = 0; k < 3; k++) begin
            wr(`PTG_IDX_PAT0 + k, pat[16*k +: 16]);
            wr(`PTG_IDX_DA0 + k, da[16*k +: 16]);
            rd(`PTG_IDX_PAT0 + k, {17'h0, pat[16*k +: 16]}, FULL);
            rd(`PTG_IDX_DA0 + k, {17'h0, da[16*k +: 16]}, FULL);
        end
        if (cnt != `PTG_CNT_CONT)
            repeat (npk) for (k = 0; k < 64; k++) begin
                gq.push_back(k < 6 ? da[8*k +: 8] : (k < 6 + np ? pat[8*(k-6) +: 8] : fix));
                gm.push_back((k < 6 + np || mode == `PTG_PM_FIX) ? 8'hFF : 8'h00);
            end
        s0 = sop_cnt;
        wr(`PTG_IDX_CTRL, 16'h1005);
        cyc(1);
        n = 0;
        while ((sop_cnt - s0 < npk || gvalid !== 1'b0) && n < 20000) begin
            @(posedge clk);
            n++;
            if (cnt == `PTG_CNT_CONT && sop_cnt - s0 == npk && n < 20000) begin
                wr(`PTG_IDX_CTRL, 16'h0004);
                cyc(1);
                n = 20000 + 1;
            end
        end
        if (n == 20000) begin
            err_total++;
            report_and_stop();
        end
        cyc(100);
        check(33'(sop_cnt - s0), 33'(npk));
        if (cnt == `PTG_CNT_CONT) begin
            check(33'(gvalid), 33'h0);
            return;
        end
        check(33'(gq.size()), 33'h0);
        rd(`PTG_IDX_STAT, mode[1] ? 33'h1100 : 33'h1000, mode[1] ? 33'h1900 : 33'h1800);
        rd(`PTG_IDX_CTRL, 33'h0, 33'h1000);
        cyc(2);
    endtask
    initial begin
        void'($urandom(32'hD20F043F));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`PTG_IDX_GCFG, `PTG_GCFG_RST, FULL);
        rd(`PTG_IDX_CTRL, `PTG_CTRL_RST, FULL);
        rd(`PTG_IDX_STAT, 33'h0, 33'h1F9FF);
        wr(`PTG_IDX_EPK_LO, 16'($urandom));
        for (i = 0; i < 6; i++) begin
            rd(`PTG_IDX_PAT0 + i, 33'h0, FULL);
            rd(`PTG_IDX_TXC_LO + i, 33'h0, FULL);
        end
        rd(`PTG_IDX_EPK_LO, 33'h0, FULL);
        rd(`PTG_IDX_EPK_HI, 33'h0, FULL);
        rd(12'h621, 33'h100000000, FULL);
        cyc(2);
        for (i = 0; i < 4; i++) begin
            c[i] = 1 + $urandom % 9;
            pulse(i, c[i]);
        end
        for (g = 0; g < 2; g++) begin
            i = g ? `PTG_IDX_RXC_LO : `PTG_IDX_TXC_LO;
            rd(i, c[2*g], FULL);
            rd(`PTG_IDX_STAT, 33'h0, 33'h0);
            rd(i + 1, 33'h0, FULL);
            rd(i + 2, c[2*g+1], FULL);
            rd(i, c[2*g], FULL);
            rd(i + 1, 33'h0, FULL);
            rd(i + 2, c[2*g+1], FULL);
            rd(i, 33'h0, FULL);
            rd(i + 2, 33'h0, FULL);
        end
        wr(`PTG_IDX_CTRL, 16'h0000);
        cyc(1);
        pulse(2, 3);
        wr(`PTG_IDX_CTRL, 16'h0004);
        rd(`PTG_IDX_RXC_LO, 33'h0, FULL);
        cyc(2);
        run(`PTG_PM_FIX, 3'h0, 1);
        run(`PTG_PM_INC, 3'h2, 100);
        corrupt <= 1'b1;
        run(2'h2, 3'h1, 10);
        corrupt <= 1'b0;
        wr(`PTG_IDX_STAT, 16'h0001);
        rd(`PTG_IDX_STAT, 33'hFC, 33'hFC);
        wr(`PTG_IDX_STAT, 16'h0002);
        rd(`PTG_IDX_EPK_LO, 33'h0, 33'h0);
        rd(`PTG_IDX_EPK_HI, 33'h0, 33'h0);
        rd(`PTG_IDX_STAT, 33'h0, 33'h0);
        wr(`PTG_IDX_STAT, 16'h0001);
        rd(`PTG_IDX_STAT, 33'h0, 33'hFF);
        rd(`PTG_IDX_EPK_LO, 33'h0, FULL);
        rd(`PTG_IDX_EPK_HI, 33'h0, FULL);
        cyc(2);
        corrupt <= 1'b1;
        run(2'h3, 3'h0, 1);
        corrupt <= 1'b0;
        rd(`PTG_IDX_STAT, 33'h0, 33'hFF);
        cyc(2);
        run(`PTG_PM_FIX, `PTG_CNT_CONT, 12);
        report_and_stop();
    end
endmodule // ptg_top_test

// *** src/ptg_map.vh ***
// Register indices, field positions, reset values and timing counts of the test traffic block
`ifndef PTG_MAP_VH
`define PTG_MAP_VH
// Register indices; byte address is four times the index
`define PTG_IDX_CTRL 12'h619
`define PTG_IDX_STAT 12'h620
`define PTG_IDX_EPK_LO 12'h622
`define PTG_IDX_EPK_HI 12'h623
`define PTG_IDX_GCFG 12'h624
`define PTG_IDX_PAT0 12'h625
`define PTG_IDX_PAT1 12'h626
`define PTG_IDX_PAT2 12'h627
`define PTG_IDX_DA0 12'h628
`define PTG_IDX_DA1 12'h629
`define PTG_IDX_DA2 12'h62A
`define PTG_IDX_TXC_LO 12'h639
`define PTG_IDX_TXC_HI 12'h63A
`define PTG_IDX_TXC_ERR 12'h63B
`define PTG_IDX_RXC_LO 12'h63C
`define PTG_IDX_RXC_HI 12'h63D
`define PTG_IDX_RXC_ERR 12'h63E
// Control register fields
`define PTG_CTRL_SEND 12
`define PTG_CTRL_MODE 3
`define PTG_CTRL_CHKEN 2
`define PTG_CTRL_GENEN 0
`define PTG_CTRL_RST 16'h0004
// Status register fields
`define PTG_STAT_DONE 12
`define PTG_STAT_BUSY 11
`define PTG_STAT_LOCK 8
`define PTG_STAT_FRZ 0
`define PTG_STAT_FCLR 1
// Generator configuration fields
`define PTG_GCFG_RST 16'h5511
`define PTG_GCFG_DATA_HI 15
`define PTG_GCFG_DATA_LO 8
`define PTG_GCFG_PM_HI 7
`define PTG_GCFG_PM_LO 6
`define PTG_GCFG_PL_HI 5
`define PTG_GCFG_PL_LO 3
`define PTG_GCFG_CNT_HI 2
`define PTG_GCFG_CNT_LO 0
`define PTG_PM_INC 2'h0
`define PTG_PM_FIX 2'h1
`define PTG_PL_MAX 3'h6
`define PTG_CNT_CONT 3'h7
// Packet shape and checker lock
`define PTG_DA_BYTES 11'h006
`define PTG_PKT_LEN 11'h040
`define PTG_IPG_LEN 11'h00C
`define PTG_LOCK_N 3'h4
`define PTG_LFSR_TAPS 8'hB8
`define PTG_LFSR_SEED 8'h01
`endif

// *** src/ptg_top.v ***
// Test traffic generator, checker and packet statistics with APB register access
`timescale 1ns/1ns
// Behaviour
// - Freeze bit snapshots all test counters
// - Freeze-clear bit freezes and arms clear-on-read
// - Freeze bit positions read back the frozen error-bit count
// - Error-bit count, saturates in single mode
// - Lock flag shows checker synchronisation
// - 32-bit errored packet count, two halves
// - Single mode stops errored packet count at ones
// - Armed: low then high read clears
// - Fixed mode payload byte, default 55
// - Mode field: incremental, fixed, pseudo-random
// - Pattern length field, capped at six
// - Packet count field, seven is continuous
// - Six pattern bytes from three words
// - Destination address in every packet
// - 32-bit transmit packet counter
// - 16-bit transmit CRC error counter
// - Transmit counters clear on ascending reads
// - 32-bit receive packet counter
// - 16-bit receive CRC error counter
// - Receive counters clear on ascending reads
// - Frame counters wrap in single and continuous mode
// - Send bit clears when generation done
// - Receive counters need checker enable
`include "ptg_map.vh"
module ptg_top (
    // Clock and reset
    input wire CLK_I,
    input wire SRST_I,
    // APB slave
    input wire [15:0] PADDR_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire PREADY_O,
    output wire PSLVERR_O,
    // Generated byte stream
    output reg [7:0] GEN_DATA_O,
    output reg GEN_VALID_O,
    output reg GEN_SOP_O,
    output reg GEN_EOP_O,
    // Checked byte stream
    input wire [7:0] CHK_DATA_I,
    input wire CHK_VALID_I,
    input wire CHK_EOP_I,
    // Frame events
    input wire TX_PKT_I,
    input wire TX_CRC_ERR_I,
    input wire RX_PKT_I,
    input wire RX_CRC_ERR_I
);
    localparam ST_IDLE = 3'h0;
    localparam ST_DA = 3'h1;
    localparam ST_PAT = 3'h2;
    localparam ST_PAY = 3'h3;
    localparam ST_IPG = 3'h4;

    function [7:0] lfsr_next;
        input [7:0] s;
        begin
            lfsr_next = s[0] ? ((s >> 1) ^ `PTG_LFSR_TAPS) : (s >> 1);
        end
    endfunction

    function [3:0] ones;
        input [7:0] v;
        integer k;
        begin
            ones = 4'h0;
            for (k = 0; k < 8; k = k + 1) begin
                ones = ones + {3'h0, v[k]};
            end
        end
    endfunction

    // Bus decode
    wire [11:0] idx = PADDR_I[13:2];
    wire acc = PSEL_I & PENABLE_I;
    wire wr = acc & PWRITE_I;
    wire rd = acc & ~PWRITE_I;
    reg mapped;
    reg [15:0] rdata;
    reg [31:0] prdata_q;

    // Registers
    reg [15:0] ctrl_q;
    reg [15:0] gcfg_q;
    reg [2:0] state_q;
    reg [47:0] pat_q;
    reg [47:0] da_q;
    reg armed_q;
    reg done_q;
    wire single = ~ctrl_q[`PTG_CTRL_MODE];
    wire chk_en = ctrl_q[`PTG_CTRL_CHKEN];
    wire stat_wr = wr & (idx == `PTG_IDX_STAT);
    wire frz = stat_wr & (PWDATA_I[`PTG_STAT_FRZ] | PWDATA_I[`PTG_STAT_FCLR]);

    // Live and frozen test counters
    reg [7:0] ebit_q;
    reg [7:0] ebit_f_q;
    reg [31:0] epk_q;
    reg [31:0] epk_f_q;
    reg pkt_err_q;
    reg [7:0] exp_q;
    reg [2:0] good_q;
    reg [2:0] bad_q;
    reg lock_q;

    // Frame counters and clear sequence trackers
    reg [31:0] txc_q;
    reg [15:0] txe_q;
    reg [31:0] rxc_q;
    reg [15:0] rxe_q;
    reg [1:0] txs_q;
    reg [1:0] rxs_q;
    reg eps_q;

    always @* begin
        mapped = 1'b1;
        case (idx)
            `PTG_IDX_CTRL: rdata = ctrl_q;
            `PTG_IDX_STAT: rdata = {3'h0, done_q, (state_q != ST_IDLE), 2'h0, lock_q, ebit_f_q};
            `PTG_IDX_EPK_LO: rdata = epk_f_q[15:0];
            `PTG_IDX_EPK_HI: rdata = epk_f_q[31:16];
            `PTG_IDX_GCFG: rdata = gcfg_q;
            `PTG_IDX_PAT0: rdata = pat_q[15:0];
            `PTG_IDX_PAT1: rdata = pat_q[31:16];
            `PTG_IDX_PAT2: rdata = pat_q[47:32];
            `PTG_IDX_DA0: rdata = da_q[15:0];
            `PTG_IDX_DA1: rdata = da_q[31:16];
            `PTG_IDX_DA2: rdata = da_q[47:32];
            `PTG_IDX_TXC_LO: rdata = txc_q[15:0];
            `PTG_IDX_TXC_HI: rdata = txc_q[31:16];
            `PTG_IDX_TXC_ERR: rdata = txe_q;
            `PTG_IDX_RXC_LO: rdata = rxc_q[15:0];
            `PTG_IDX_RXC_HI: rdata = rxc_q[31:16];
            `PTG_IDX_RXC_ERR: rdata = rxe_q;
            default: begin
                rdata = 16'h0000;
                mapped = 1'b0;
            end
        endcase
    end

    // Zero wait states; read data is latched in the setup cycle
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = acc & ~mapped;
    assign PRDATA_O = prdata_q;

    always @(posedge CLK_I) begin
        if (SRST_I) begin
            prdata_q <= 32'h0000_0000;
        end else if (PSEL_I & ~PENABLE_I) begin
            prdata_q <= {16'h0000, rdata};
        end
    end

    // Generator
    reg [10:0] bcnt_q;
    reg [20:0] pkts_q;
    reg [7:0] inc_q;
    reg [7:0] glfsr_q;
    reg [20:0] target;
    reg [7:0] pay;
    // Offset into the pattern, taken in 11 bits so the index never goes negative
    wire [10:0] pat_off = bcnt_q - `PTG_DA_BYTES;
    wire [2:0] plen = (gcfg_q[`PTG_GCFG_PL_HI:`PTG_GCFG_PL_LO] > `PTG_PL_MAX) ?
        `PTG_PL_MAX : gcfg_q[`PTG_GCFG_PL_HI:`PTG_GCFG_PL_LO];
    wire cont = (gcfg_q[`PTG_GCFG_CNT_HI:`PTG_GCFG_CNT_LO] == `PTG_CNT_CONT);
    wire send = ctrl_q[`PTG_CTRL_SEND] & ctrl_q[`PTG_CTRL_GENEN];
    wire last = (bcnt_q == `PTG_PKT_LEN - 11'h001);
    wire fin = (state_q == ST_PAY) & last & ~cont & (pkts_q + 21'h000001 >= target);

    always @* begin
        case (gcfg_q[`PTG_GCFG_CNT_HI:`PTG_GCFG_CNT_LO])
            3'h0: target = 21'd1;
            3'h1: target = 21'd10;
            3'h2: target = 21'd100;
            3'h3: target = 21'd1000;
            3'h4: target = 21'd10000;
            3'h5: target = 21'd100000;
            default: target = 21'd1000000;
        endcase
        case (gcfg_q[`PTG_GCFG_PM_HI:`PTG_GCFG_PM_LO])
            `PTG_PM_INC: pay = inc_q;
            `PTG_PM_FIX: pay = gcfg_q[`PTG_GCFG_DATA_HI:`PTG_GCFG_DATA_LO];
            default: pay = glfsr_q;
        endcase
    end

    always @(posedge CLK_I) begin
        if (SRST_I) begin
            state_q <= ST_IDLE;
            bcnt_q <= 11'h000;
            pkts_q <= 21'h000000;
            inc_q <= 8'h00;
            glfsr_q <= `PTG_LFSR_SEED;
            GEN_DATA_O <= 8'h00;
            GEN_VALID_O <= 1'b0;
            GEN_SOP_O <= 1'b0;
            GEN_EOP_O <= 1'b0;
        end else begin
            GEN_VALID_O <= 1'b0;
            GEN_SOP_O <= 1'b0;
            GEN_EOP_O <= 1'b0;
            bcnt_q <= bcnt_q + 11'h001;
            case (state_q)
                ST_IDLE: begin
                    bcnt_q <= 11'h000;
                    pkts_q <= 21'h000000;
                    if (send) begin
                        state_q <= ST_DA;
                    end
                end
                ST_DA: begin
                    GEN_DATA_O <= da_q[bcnt_q[2:0] * 8 +: 8];
                    GEN_VALID_O <= 1'b1;
                    GEN_SOP_O <= (bcnt_q == 11'h000);
                    if (bcnt_q == `PTG_DA_BYTES - 11'h001) begin
                        state_q <= (plen == 3'h0) ? ST_PAY : ST_PAT;
                    end
                end
                ST_PAT: begin
                    GEN_DATA_O <= pat_q[pat_off[2:0] * 8 +: 8];
                    GEN_VALID_O <= 1'b1;
                    if (bcnt_q == `PTG_DA_BYTES + {8'h00, plen} - 11'h001) begin
                        state_q <= ST_PAY;
                    end
                end
                ST_PAY: begin
                    GEN_DATA_O <= pay;
                    GEN_VALID_O <= 1'b1;
                    inc_q <= inc_q + 8'h01;
                    glfsr_q <= lfsr_next(glfsr_q);
                    if (last) begin
                        GEN_EOP_O <= 1'b1;
                        bcnt_q <= 11'h000;
                        pkts_q <= pkts_q + 21'h000001;
                        state_q <= fin ? ST_IDLE : ST_IPG;
                    end
                end
                ST_IPG: begin
                    // Dropping enable stops a continuous run between packets; a write cannot clear send
                    if (bcnt_q == `PTG_IPG_LEN - 11'h001) begin
                        bcnt_q <= 11'h000;
                        state_q <= send ? ST_DA : ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Control and configuration registers
    always @(posedge CLK_I) begin
        if (SRST_I) begin
            ctrl_q <= `PTG_CTRL_RST;
            gcfg_q <= `PTG_GCFG_RST;
            pat_q <= 48'h0000_0000_0000;
            da_q <= 48'h0000_0000_0000;
            armed_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (wr) begin
                case (idx)
                    `PTG_IDX_CTRL: ctrl_q <= PWDATA_I[15:0] | (ctrl_q & (16'h0001 << `PTG_CTRL_SEND));
                    `PTG_IDX_GCFG: gcfg_q <= PWDATA_I[15:0];
                    `PTG_IDX_PAT0: pat_q[15:0] <= PWDATA_I[15:0];
                    `PTG_IDX_PAT1: pat_q[31:16] <= PWDATA_I[15:0];
                    `PTG_IDX_PAT2: pat_q[47:32] <= PWDATA_I[15:0];
                    `PTG_IDX_DA0: da_q[15:0] <= PWDATA_I[15:0];
                    `PTG_IDX_DA1: da_q[31:16] <= PWDATA_I[15:0];
                    `PTG_IDX_DA2: da_q[47:32] <= PWDATA_I[15:0];
                    default: ;
                endcase
            end
            if (wr & (idx == `PTG_IDX_CTRL) & PWDATA_I[`PTG_CTRL_SEND]) begin
                done_q <= 1'b0;
            end
            if (fin) begin
                ctrl_q[`PTG_CTRL_SEND] <= 1'b0;
                done_q <= 1'b1;
            end
            if (frz) begin
                armed_q <= PWDATA_I[`PTG_STAT_FCLR];
            end
        end
    end

    // Checker: each byte predicts the next, so lock needs no seed exchange
    wire [7:0] ebits = CHK_VALID_I ? (CHK_DATA_I ^ exp_q) : 8'h00;
    wire berr = (ebits != 8'h00);
    wire [8:0] ebit_sum = {1'b0, ebit_q} + {5'h00, ones(ebits)};
    wire epk_clr = armed_q & rd & (idx == `PTG_IDX_EPK_HI) & eps_q;
    wire ebit_clr = armed_q & rd & (idx == `PTG_IDX_STAT);

    always @(posedge CLK_I) begin
        if (SRST_I) begin
            exp_q <= 8'h00;
            good_q <= 3'h0;
            bad_q <= 3'h0;
            lock_q <= 1'b0;
            ebit_q <= 8'h00;
            epk_q <= 32'h0000_0000;
            pkt_err_q <= 1'b0;
            ebit_f_q <= 8'h00;
            epk_f_q <= 32'h0000_0000;
            eps_q <= 1'b0;
        end else begin
            if (CHK_VALID_I & chk_en) begin
                exp_q <= lfsr_next(CHK_DATA_I);
                // lock after good run, drop after bad run
                if (berr) begin
                    good_q <= 3'h0;
                    bad_q <= (bad_q == `PTG_LOCK_N) ? bad_q : bad_q + 3'h1;
                    if (bad_q == `PTG_LOCK_N - 3'h1) begin
                        lock_q <= 1'b0;
                    end
                end else begin
                    bad_q <= 3'h0;
                    good_q <= (good_q == `PTG_LOCK_N) ? good_q : good_q + 3'h1;
                    if (good_q == `PTG_LOCK_N - 3'h1) begin
                        lock_q <= 1'b1;
                    end
                end
                if (lock_q) begin
                    ebit_q <= (single & ebit_sum[8]) ? 8'hFF : ebit_sum[7:0];
                    pkt_err_q <= (pkt_err_q | berr) & ~CHK_EOP_I;
                    if (CHK_EOP_I & (pkt_err_q | berr)) begin
                        epk_q <= (single & (&epk_q)) ? epk_q : epk_q + 32'h0000_0001;
                    end
                end
            end
            // sequence restarts on any other read
            if (rd) begin
                eps_q <= (idx == `PTG_IDX_EPK_LO);
            end
            if (frz) begin
                ebit_f_q <= ebit_q;
                epk_f_q <= epk_q;
            end
            if (ebit_clr) begin
                ebit_q <= 8'h00;
                ebit_f_q <= 8'h00;
            end
            if (epk_clr) begin
                epk_q <= 32'h0000_0000;
                epk_f_q <= 32'h0000_0000;
            end
        end
    end

    // Frame counters; a clear in the same cycle as an event keeps the event
    wire tx_clr = rd & (idx == `PTG_IDX_TXC_ERR) & (txs_q == 2'h2);
    wire rx_clr = rd & (idx == `PTG_IDX_RXC_ERR) & (rxs_q == 2'h2);
    wire rx_ev = RX_PKT_I & chk_en;
    wire rx_er = RX_CRC_ERR_I & chk_en;

    always @(posedge CLK_I) begin
        if (SRST_I) begin
            txc_q <= 32'h0000_0000;
            txe_q <= 16'h0000;
            rxc_q <= 32'h0000_0000;
            rxe_q <= 16'h0000;
            txs_q <= 2'h0;
            rxs_q <= 2'h0;
        end else begin
            txc_q <= (tx_clr ? 32'h0000_0000 : txc_q) + {31'h0, TX_PKT_I};
            txe_q <= (tx_clr ? 16'h0000 : txe_q) + {15'h0, TX_CRC_ERR_I};
            rxc_q <= (rx_clr ? 32'h0000_0000 : rxc_q) + {31'h0, rx_ev};
            rxe_q <= (rx_clr ? 16'h0000 : rxe_q) + {15'h0, rx_er};
            if (rd) begin
                if (idx == `PTG_IDX_TXC_LO) begin
                    txs_q <= 2'h1;
                end else if (idx == `PTG_IDX_TXC_HI && txs_q == 2'h1) begin
                    txs_q <= 2'h2;
                end else begin
                    txs_q <= 2'h0;
                end
                if (idx == `PTG_IDX_RXC_LO) begin
                    rxs_q <= 2'h1;
                end else if (idx == `PTG_IDX_RXC_HI && rxs_q == 2'h1) begin
                    rxs_q <= 2'h2;
                end else begin
                    rxs_q <= 2'h0;
                end
            end
        end
    end
endmodule // ptg_top
